// ==== src/cgs_channel_gpio_sequencer_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cgs_regs.svh"

module cgs_channel_gpio_sequencer_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register access from the serial front end
  input wire cgs_pkg::cgs_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // channel pins
  input wire logic [7:0] pin_in,
  output cgs_pkg::cgs_pin_drive_s pin_drive,
  // converter core
  input wire logic conv_step,
  output cgs_pkg::cgs_core_cfg_s core_cfg
);
  import cgs_pkg::*;

  logic [7:0] osc_timing_ff;
  logic [7:0] general_setup_ff;
  logic [7:0] pin_function_ff;
  logic [7:0] gpio_direction_ff;
  logic [7:0] drive_style_ff;
  logic [7:0] output_level_ff;
  logic [7:0] input_level_ff;
  logic [7:0] seq_control_ff;
  logic [7:0] manual_pick_ff;
  logic [7:0] scan_enable_ff;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  cgs_pin_drive_s pin_drive_ff;
  logic osc_choice_ff;
  logic [3:0] clk_div_ff;
  logic [7:0] analog_input_ff;
  logic scan_active_ff;
  logic [2:0] conv_channel_ff;
  logic conv_valid_ff;
  cgs_scan_state_e scan_state_ff;
  cgs_scan_state_e nxt_scan_state;
  logic [2:0] scan_ch_ff;
  logic [2:0] nxt_scan_ch;
  logic [7:0] nxt_rdata;
  logic [7:0] gpio_mask;
  logic [7:0] out_mask;
  logic force_analog;
  cgs_scan_mode_e scan_mode;
  logic scan_go;
  logic wr;
  logic [7:0] scan_pool;
  logic scan_running;
  logic manual_ok;

  // pick the next enabled channel strictly above cur, wrapping round
  function automatic logic [2:0] next_enabled(input logic [2:0] cur,
                                              input logic [7:0] en);
    logic [2:0] pick;
    logic [2:0] idx;
    pick = cur;
    for (int i = 7; i >= 1; i--) begin
      idx = 3'(cur + 3'(i));
      if (en[idx]) begin
        pick = idx;
      end
    end
    return pick;
  endfunction

  // lowest enabled channel, used when a scan starts
  function automatic logic [2:0] first_enabled(input logic [7:0] en);
    logic [2:0] pick;
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i]) begin
        pick = 3'(i);
      end
    end
    return pick;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return wr && (a == b);
  endfunction

  assign wr = reg_req.wr_en;
  assign force_analog = general_setup_ff[`CGS_FORCE_ANALOG_BIT];
  assign scan_mode = cgs_scan_mode_e'(seq_control_ff[`CGS_SCAN_MODE_LSB +: 2]);
  assign scan_go = seq_control_ff[`CGS_SCAN_GO_BIT];
  // force_all_analog overrides the pin function
  assign gpio_mask = force_analog ? `CGS_RESET_VALUE : pin_function_ff;
  // outputs only where the channel is a GPIO output
  assign out_mask = gpio_mask & gpio_direction_ff;
  // analog channels the auto scan may visit; GPIO channels are skipped
  assign scan_pool = scan_enable_ff & ~gpio_mask;
  assign scan_running = (scan_state_ff == CGS_SCAN_RUN);
  // reserved codes and GPIO channels never yield a valid manual pick
  assign manual_ok = (scan_state_ff == CGS_SCAN_MANUAL) &&
    !manual_pick_ff[3] && !gpio_mask[manual_pick_ff[2:0]];

  // register writes; reserved bits are masked so they never store
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      osc_timing_ff <= `CGS_RESET_VALUE;
      general_setup_ff <= `CGS_RESET_VALUE;
    end else begin
      if (hit(reg_req.addr, `CGS_OSC_TIMING_ADDR)) begin
        osc_timing_ff <= reg_req.wdata & `CGS_OSC_TIMING_MASK;
      end
      if (hit(reg_req.addr, `CGS_GENERAL_SETUP_ADDR)) begin
        general_setup_ff <= reg_req.wdata & `CGS_GENERAL_SETUP_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_function_ff <= `CGS_RESET_VALUE;
      gpio_direction_ff <= `CGS_RESET_VALUE;
      drive_style_ff <= `CGS_RESET_VALUE;
      output_level_ff <= `CGS_RESET_VALUE;
    end else begin
      if (hit(reg_req.addr, `CGS_PIN_FUNCTION_ADDR)) begin
        pin_function_ff <= reg_req.wdata;
      end
      if (hit(reg_req.addr, `CGS_GPIO_DIRECTION_ADDR)) begin
        gpio_direction_ff <= reg_req.wdata;
      end
      if (hit(reg_req.addr, `CGS_DRIVE_STYLE_ADDR)) begin
        drive_style_ff <= reg_req.wdata;
      end
      if (hit(reg_req.addr, `CGS_OUTPUT_LEVEL_ADDR)) begin
        output_level_ff <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_control_ff <= `CGS_RESET_VALUE;
      manual_pick_ff <= `CGS_RESET_VALUE;
      scan_enable_ff <= `CGS_RESET_VALUE;
    end else begin
      if (hit(reg_req.addr, `CGS_SEQ_CONTROL_ADDR)) begin
        seq_control_ff <= reg_req.wdata & `CGS_SEQ_CONTROL_MASK;
      end
      if (hit(reg_req.addr, `CGS_MANUAL_PICK_ADDR)) begin
        manual_pick_ff <= reg_req.wdata & `CGS_MANUAL_PICK_MASK;
      end
      if (hit(reg_req.addr, `CGS_SCAN_ENABLE_ADDR)) begin
        scan_enable_ff <= reg_req.wdata;
      end
    end
  end

  // input levels are sampled every cycle; non-input channels read zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      input_level_ff <= `CGS_RESET_VALUE;
    end else begin
      input_level_ff <= pin_in & gpio_mask & ~gpio_direction_ff;
    end
  end

  // open-drain drives only a low; a high is left to the external pullup
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_drive_ff <= '0;
    end else begin
      pin_drive_ff.out_level <= output_level_ff & out_mask;
      pin_drive_ff.out_enable <=
        out_mask & (drive_style_ff | ~output_level_ff);
    end
  end

  always_comb begin
    nxt_rdata = `CGS_RESET_VALUE;
    unique case (reg_req.addr)
      `CGS_OSC_TIMING_ADDR: nxt_rdata = osc_timing_ff;
      `CGS_GENERAL_SETUP_ADDR: nxt_rdata = general_setup_ff;
      `CGS_PIN_FUNCTION_ADDR: nxt_rdata = pin_function_ff;
      `CGS_GPIO_DIRECTION_ADDR: nxt_rdata = gpio_direction_ff;
      `CGS_DRIVE_STYLE_ADDR: nxt_rdata = drive_style_ff;
      `CGS_OUTPUT_LEVEL_ADDR: nxt_rdata = output_level_ff;
      `CGS_INPUT_LEVEL_ADDR: nxt_rdata = input_level_ff;
      `CGS_SEQ_CONTROL_ADDR: nxt_rdata = seq_control_ff;
      `CGS_MANUAL_PICK_ADDR: nxt_rdata = manual_pick_ff;
      `CGS_SCAN_ENABLE_ADDR: nxt_rdata = scan_enable_ff;
      // unmapped offsets read zero
      default: nxt_rdata = `CGS_RESET_VALUE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata_ff <= `CGS_RESET_VALUE;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // sequencer: auto scan walks enabled channels on each conv_step
  always_comb begin
    nxt_scan_state = scan_state_ff;
    nxt_scan_ch = scan_ch_ff;
    unique case (scan_state_ff)
      CGS_SCAN_IDLE: begin
        if (scan_mode == CGS_MODE_AUTO && scan_go) begin
          nxt_scan_state = CGS_SCAN_RUN;
          nxt_scan_ch = first_enabled(scan_pool);
        end else if (scan_mode == CGS_MODE_MANUAL) begin
          nxt_scan_state = CGS_SCAN_MANUAL;
        end
      end
      CGS_SCAN_RUN: begin
        if (scan_mode != CGS_MODE_AUTO || !scan_go) begin
          nxt_scan_state = CGS_SCAN_IDLE;
        end else if (conv_step) begin
          nxt_scan_ch = next_enabled(scan_ch_ff, scan_pool);
        end
      end
      CGS_SCAN_MANUAL: begin
        if (scan_mode != CGS_MODE_MANUAL) begin
          nxt_scan_state = CGS_SCAN_IDLE;
        end
      end
      default: nxt_scan_state = CGS_SCAN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scan_state_ff <= CGS_SCAN_IDLE;
      scan_ch_ff <= 3'h0;
    end else begin
      scan_state_ff <= nxt_scan_state;
      scan_ch_ff <= nxt_scan_ch;
    end
  end

  // timing setup as seen by the core
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      osc_choice_ff <= 1'b0;
      clk_div_ff <= 4'h0;
    end else begin
      osc_choice_ff <= osc_timing_ff[`CGS_OSC_CHOICE_BIT];
      clk_div_ff <= osc_timing_ff[`CGS_CLK_DIV_LSB +: 4];
    end
  end

  // channel map as seen by the core
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      analog_input_ff <= `CGS_RESET_VALUE;
      scan_active_ff <= 1'b0;
    end else begin
      analog_input_ff <= ~gpio_mask;
      // a started scan with nothing to visit stays quiet towards the core
      scan_active_ff <= scan_running && (|scan_pool);
    end
  end

  // conversion channel; a pick the host should never make is flagged
  // invalid rather than blocked, so the core can drop its result
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_channel_ff <= 3'h0;
      conv_valid_ff <= 1'b0;
    end else if (scan_running) begin
      conv_channel_ff <= scan_ch_ff;
      conv_valid_ff <= scan_pool[scan_ch_ff];
    end else begin
      conv_channel_ff <= manual_pick_ff[2:0];
      conv_valid_ff <= manual_ok;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign pin_drive = pin_drive_ff;
  assign core_cfg = '{osc_choice_ff, clk_div_ff, analog_input_ff,
                      scan_active_ff, conv_channel_ff, conv_valid_ff};
endmodule

`default_nettype wire

// ==== src/cgs_regs.svh ====
`ifndef CGS_REGS_SVH
`define CGS_REGS_SVH

// register offsets
`define CGS_GENERAL_SETUP_ADDR 8'h01
`define CGS_OSC_TIMING_ADDR 8'h04
`define CGS_PIN_FUNCTION_ADDR 8'h05
`define CGS_GPIO_DIRECTION_ADDR 8'h07
`define CGS_DRIVE_STYLE_ADDR 8'h09
`define CGS_OUTPUT_LEVEL_ADDR 8'h0b
`define CGS_INPUT_LEVEL_ADDR 8'h0d
`define CGS_SEQ_CONTROL_ADDR 8'h10
`define CGS_MANUAL_PICK_ADDR 8'h11
`define CGS_SCAN_ENABLE_ADDR 8'h12

// field positions
`define CGS_OSC_CHOICE_BIT 4
`define CGS_CLK_DIV_LSB 0
`define CGS_FORCE_ANALOG_BIT 2
`define CGS_SCAN_GO_BIT 4
`define CGS_SCAN_MODE_LSB 0
`define CGS_MANUAL_CH_LSB 0

// writable masks, reserved bits are held at zero
`define CGS_OSC_TIMING_MASK 8'h1f
`define CGS_GENERAL_SETUP_MASK 8'h04
`define CGS_SEQ_CONTROL_MASK 8'h13
`define CGS_MANUAL_PICK_MASK 8'h0f

// reset values
`define CGS_RESET_VALUE 8'h00

`endif

// ==== src/cgs_pkg.sv ====
package cgs_pkg;
  typedef enum logic [1:0] {
    CGS_MODE_MANUAL = 2'h0,
    CGS_MODE_AUTO = 2'h1,
    CGS_MODE_ON_THE_FLY = 2'h2,
    CGS_MODE_RESERVED = 2'h3
  } cgs_scan_mode_e;

  typedef enum logic [2:0] {
    CGS_SCAN_IDLE = 3'b001,
    CGS_SCAN_RUN = 3'b010,
    CGS_SCAN_MANUAL = 3'b100
  } cgs_scan_state_e;

  // register access request from the serial front end
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cgs_reg_req_s;

  // per-channel pin drive, one bit per channel
  typedef struct packed {
    logic [7:0] out_level;
    logic [7:0] out_enable;
  } cgs_pin_drive_s;

  // configuration seen by the converter core
  typedef struct packed {
    logic osc_choice;
    logic [3:0] clk_div;
    logic [7:0] analog_input;
    logic scan_active;
    logic [2:0] conv_channel;
    logic conv_channel_valid;
  } cgs_core_cfg_s;
endpackage

// ==== tb/cgs_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module cgs_regs_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register access
  input wire cgs_pkg::cgs_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // pins and core
  input wire logic [7:0] pin_in,
  input wire cgs_pkg::cgs_pin_drive_s pin_drive,
  input wire logic conv_step,
  input wire cgs_pkg::cgs_core_cfg_s core_cfg
);
  import cgs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(a);
    reg_req.rd_en && reg_req.addr == a;
  endsequence
  sequence s_force_on;
    reg_req.wr_en && reg_req.addr == 8'h01 && reg_req.wdata[2];
  endsequence
  property p_rvalid;
    reg_req.rd_en |=> reg_rvalid;
  endproperty
  property p_no_rvalid;
    !reg_req.rd_en |=> !reg_rvalid;
  endproperty
  property p_rdata_hold;
    !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  property p_rsv_seq;
    s_rd(8'h10) |=> (reg_rdata & 8'hec) == 8'h00;
  endproperty
  property p_rsv_osc;
    s_rd(8'h04) |=> reg_rdata[7:5] == 3'h0;
  endproperty
  property p_rsv_pick;
    s_rd(8'h11) |=> reg_rdata[7:4] == 4'h0;
  endproperty
  // the core sees a stored setting one cycle after the store
  property p_osc_follow;
    logic [7:0] v;
    (reg_req.wr_en && reg_req.addr == 8'h04, v = reg_req.wdata) |->
      ##2 core_cfg.osc_choice == v[4] && core_cfg.clk_div == v[3:0];
  endproperty
  property p_force_analog;
    s_force_on |-> ##2 pin_drive.out_enable == 8'h00 &&
      core_cfg.analog_input == 8'hff;
  endproperty
  // no channel that the core treats as analog is ever driven
  property p_no_drive_analog;
    ((pin_drive.out_enable | pin_drive.out_level) & core_cfg.analog_input)
      == 8'h00;
  endproperty
  a_no_drive_analog: assert property (p_no_drive_analog)
    else $error("analog driven");
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  a_no_rvalid: assert property (p_no_rvalid) else $error("stray answer");
  a_rdata_hold: assert property (p_rdata_hold) else $error("data moved");
  a_rsv_seq: assert property (p_rsv_seq) else $error("reserved set");
  a_rsv_osc: assert property (p_rsv_osc) else $error("reserved set");
  a_rsv_pick: assert property (p_rsv_pick) else $error("reserved set");
  a_osc_follow: assert property (p_osc_follow) else $error("osc wrong");
  a_force_analog: assert property (p_force_analog) else $error("not analog");
endmodule
bind cgs_channel_gpio_sequencer_regs cgs_regs_properties cgs_regs_properties_inst (
  .ref_clk, .reset_n, .reg_req, .reg_rdata, .reg_rvalid, .pin_in, .pin_drive,
  .conv_step, .core_cfg);
`default_nettype wire

// ==== tb/cgs_pin_env.sv ====
`timescale 1ns/1ps
`default_nettype none
module cgs_pin_env (
  // drive from the device
  input wire cgs_pkg::cgs_pin_drive_s pin_drive,
  // board level where nothing drives, pull-up included
  input wire logic [7:0] board_level,
  // resolved pin levels
  output logic [7:0] pin_level
);
  // a released open-drain high shows the pull-up, not the stored level
  assign pin_level = (pin_drive.out_enable & pin_drive.out_level) |
    (~pin_drive.out_enable & board_level);
endmodule
`default_nettype wire

// ==== tb/cgs_channel_gpio_sequencer_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module cgs_channel_gpio_sequencer_regs_test;
  import cgs_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  cgs_reg_req_s reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [7:0] pin_in;
  logic [7:0] board_level = 8'ha0;
  cgs_pin_drive_s pin_drive;
  logic conv_step = 1'b0;
  cgs_core_cfg_s core_cfg;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] addrs [9] = '{8'h04, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h10,
    8'h11, 8'h12};
  logic [7:0] masks [9] = '{8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h13,
    8'h0f, 8'hff};
  always #5 ref_clk = ~ref_clk;
  cgs_channel_gpio_sequencer_regs cgs_channel_gpio_sequencer_regs_inst (
    .ref_clk, .reset_n, .reg_req, .reg_rdata, .reg_rvalid, .pin_in,
    .pin_drive, .conv_step, .core_cfg);
  cgs_pin_env cgs_pin_env_inst (.pin_drive, .board_level, .pin_level(pin_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one idle cycle after each strobe keeps two requests from sharing a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{1'b1, 1'b0, a, d};
    idle(1);
    reg_req.wr_en = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    idle(1);
    // the answer stands for one cycle only, so look before moving on
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, exp);
    reg_req.rd_en = 1'b0;
    idle(1);
  endtask
  task automatic step(input logic [7:0] exp);
    conv_step = 1'b1;
    idle(1);
    conv_step = 1'b0;
    idle(3);
    chk({core_cfg.scan_active, 4'h0, core_cfg.conv_channel}, exp);
  endtask
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    idle(10);
    reset_n = 1'b1;
    idle(1);
    for (int i = 0; i < 9; i++) rd(addrs[i], 8'h00);
    rd(8'h02, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], masks[i]);
    end
    chk({3'h0, core_cfg.osc_choice, core_cfg.clk_div}, 8'h1f);
    wr(8'h04, 8'h00);
    idle(1);
    chk({3'h0, core_cfg.osc_choice, core_cfg.clk_div}, 8'h00);
    $display("register access done");
    wr(8'h07, 8'h0f);
    wr(8'h09, 8'h03);
    wr(8'h0b, 8'h05);
    idle(2);
    chk(pin_drive.out_enable, 8'h0b);
    chk(pin_drive.out_level, 8'h05);
    rd(8'h0d, 8'ha0);
    board_level = 8'h50;
    idle(2);
    rd(8'h0d, 8'h50);
    wr(8'h05, 8'h0e);
    idle(1);
    chk(pin_drive.out_enable, 8'h0a);
    chk(core_cfg.analog_input, 8'hf1);
    rd(8'h0d, 8'h00);
    wr(8'h05, 8'hff);
    wr(8'h01, 8'h04);
    idle(1);
    chk(pin_drive.out_enable, 8'h00);
    chk(core_cfg.analog_input, 8'hff);
    rd(8'h0d, 8'h00);
    wr(8'h01, 8'h00);
    $display("pin tests done");
    wr(8'h05, 8'h00);
    wr(8'h12, 8'h05);
    wr(8'h10, 8'h11);
    idle(2);
    chk({core_cfg.scan_active, 4'h0, core_cfg.conv_channel}, 8'h80);
    step(8'h82);
    step(8'h80);
    wr(8'h10, 8'h01);
    idle(2);
    chk({7'h00, core_cfg.scan_active}, 8'h00);
    for (int m = 2; m < 4; m++) begin
      wr(8'h10, 8'h10 | m[7:0]);
      idle(2);
      chk({7'h00, core_cfg.scan_active}, 8'h00);
    end
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h03);
    idle(2);
    chk({core_cfg.conv_channel_valid, 4'h0, core_cfg.conv_channel},
      8'h83);
    wr(8'h11, 8'h08);
    idle(2);
    chk({7'h00, core_cfg.conv_channel_valid}, 8'h00);
    wr(8'h11, 8'h03);
    wr(8'h05, 8'h08);
    idle(2);
    chk({7'h00, core_cfg.conv_channel_valid}, 8'h00);
    $display("scan tests done");
    complete_run();
  end
endmodule
`default_nettype wire
